// ===== rtc_defs.svh
// Register offsets, reset values and timing constants of the reference clock selector
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// Register byte offsets
`define RTC_OFF_CTRL     8'h00
`define RTC_OFF_STATUS   8'h04
`define RTC_OFF_FREQ     8'h08
// Control field positions
`define RTC_CTRL_EN      0
`define RTC_CTRL_CMD_LO  1
`define RTC_CTRL_CMD_HI  2
`define RTC_CTRL_EXT     3
// Reset values
`define RTC_RST_CTRL     4'h0
`define RTC_RST_HRDATA   32'h0000_0000
// Oscillator increment for 10.24 MHz out of 50 MHz
`define RTC_NOM_INC      32'h346D_C5D6
`define RTC_TRACK_STEP   32'h0000_4000
`define RTC_LOCK_STEP    32'h0000_0010
// Clock rate and derived timing
`define RTC_CLK_HZ       50000000
`define RTC_WIN_US       1000
`define RTC_WIN_CYC      (`RTC_WIN_US * (`RTC_CLK_HZ / 1000000))
`define RTC_HOLDOFF_MS   1000
`define RTC_HOLDOFF_CYC  (`RTC_HOLDOFF_MS * (`RTC_CLK_HZ / 1000))
`define RTC_BLINK_MS     250
`define RTC_BLINK_CYC    (`RTC_BLINK_MS * (`RTC_CLK_HZ / 1000))
// Reference measurement per window
`define RTC_REF_EXP      16'h0008
`define RTC_SPEC_TOL     16'h0001
`define RTC_RATIO        16'h0500
`define RTC_LOCK_TOL     16'h0004
`define RTC_BURST_TOL    16'h0040
`endif

// ===== rtc_pkg.sv
// Types of the reference clock selector
package rtc_pkg;

  // Controller states, one-hot
  typedef enum logic [3:0] {
    RTC_FREE   = 4'b0001,
    RTC_TRACK  = 4'b0010,
    RTC_LOCKED = 4'b0100,
    RTC_HOLD   = 4'b1000
  } rtc_state_e;

  // Software mode commands
  typedef enum logic [1:0] {
    RTC_CMD_FREE = 2'b00,
    RTC_CMD_PRI  = 2'b01,
    RTC_CMD_SEC  = 2'b10
  } rtc_cmd_e;

  // All state of the selector
  typedef struct packed {
    rtc_state_e       state;
    logic             sel;
    logic [31:0]      inc;
    logic [31:0]      nco;
    logic             sysclk;
    logic [31:0]      win;
    logic [1:0][15:0] rcnt;
    logic [15:0]      scnt;
    logic [1:0]       prev;
    logic [1:0]       ok;
    logic [1:0]       known;
    logic             exact;
    logic [31:0]      hold_t;
    logic [31:0]      blink;
    logic             flash;
    logic             led;
    logic             en;
    rtc_cmd_e         cmd;
    logic             ext;
    logic             wr_pend;
    logic [7:0]       waddr;
    logic [31:0]      hrdata;
    logic             hready;
  } rtc_regs_s;

endpackage

// ===== rtc_clock_selector.sv
// Reference tracking clock selector with AHB-Lite register slave
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "rtc_defs.svh"

// Notes on behaviour
// - Tracking and free-run modes both supported
// - Track frequency, lock when close, refine
// - Green indicator flashes while tracking
// - Free-run ignores references, uses own clock
// - Phase-locked system clock, two references
// - Auto switch when used reference fails
// - Both references bad gives holdover
// - Primary command selects primary, qualifies both
// - Primary fails, move if secondary good
// - Return to primary once it recovers
// - Secondary command selects secondary, qualifies both
// - Secondary fails, move if primary good
// - Return to secondary once it recovers
// - Timeout blocks back and forth switching
// - Hold frequency on absence or bursts
// - No quality record forces free-run
// - Free-run command and enable enter free-run
// - References all auxiliary or all trunk
module rtc_clock_selector #(
  parameter int unsigned WIN_CYC     = `RTC_WIN_CYC,
  parameter int unsigned HOLDOFF_CYC = `RTC_HOLDOFF_CYC,
  parameter int unsigned BLINK_CYC   = `RTC_BLINK_CYC,
  parameter logic [15:0] REF_EXP     = `RTC_REF_EXP,
  parameter logic [15:0] SPEC_TOL    = `RTC_SPEC_TOL,
  parameter logic [15:0] RATIO       = `RTC_RATIO,
  parameter logic [15:0] LOCK_TOL    = `RTC_LOCK_TOL,
  parameter logic [15:0] BURST_TOL   = `RTC_BURST_TOL
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [1:0]  REF_TRUNK,
  input  wire logic [1:0]  REF_AUX,
  output logic             SYS_CLK,
  output logic             SYS_CLK_EN,
  output logic             LED_GREEN
);

  rtc_pkg::rtc_regs_s q;
  rtc_pkg::rtc_regs_s n;

  logic [1:0]        ref_in;
  logic [1:0]        edge_s;
  logic [1:0]        ok_now;
  logic [1:0]        seen;
  logic [1:0][15:0]  rcnt_inc;
  logic              win_end;
  logic              sys_edge;
  logic              act;
  logic              pref;
  logic              want;
  logic              have_want;
  logic              do_switch;
  logic [31:0]       rprod;
  logic signed [31:0] err;
  logic [31:0]       aerr;
  logic              addr_ph;

  assign win_end  = (q.win == WIN_CYC - 1);
  assign sys_edge = q.nco[31] & ~q.sysclk;
  assign addr_ph  = HSEL & HTRANS[1] & HREADY;

  // Per-reference source mux, edge count and qualification
  for (genvar i = 0; i < 2; i++) begin : g_ref
    logic [15:0] dev;
    // Rising edges only; a silent reference reads zero at either level
    assign ref_in[i]   = q.ext ? REF_AUX[i] : REF_TRUNK[i]; // Never a mix of sets
    assign edge_s[i]   = ref_in[i] & ~q.prev[i];
    assign rcnt_inc[i] = q.rcnt[i] + {15'h0000, edge_s[i]};
    assign dev         = (rcnt_inc[i] > REF_EXP) ? rcnt_inc[i] - REF_EXP
                                                 : REF_EXP - rcnt_inc[i];
    assign ok_now[i]   = (dev <= SPEC_TOL); // Both always qualified
    assign seen[i]     = (rcnt_inc[i] != 16'h0000);
  end

  // Next-state logic for the whole selector
  always_comb begin
    n         = q;
    act       = q.en && (q.cmd != rtc_pkg::RTC_CMD_FREE) && (q.known != 2'b00);
    pref      = (q.cmd == rtc_pkg::RTC_CMD_SEC);
    want      = pref;
    have_want = 1'b1;
    rprod     = 32'(q.rcnt[q.sel]) * 32'(RATIO);
    err       = $signed(32'(q.scnt)) - $signed(rprod);
    aerr      = err[31] ? 32'(-err) : 32'(err);
    // Preferred reference first, the other only if it is good
    if (ok_now[pref]) begin
      want = pref;
    end else if (ok_now[~pref]) begin
      want = ~pref; // Fallback only to a good reference
    end else begin
      have_want = 1'b0;
    end
    do_switch = act && have_want && (want != q.sel) && (q.hold_t == 32'h0000_0000);

    // Numerically controlled oscillator gives the system clock
    n.nco    = q.nco + q.inc; // Output follows selected reference only in track and lock states
    n.sysclk = q.nco[31];
    n.prev   = ref_in;
    n.scnt   = q.scnt + {15'h0000, sys_edge};
    n.rcnt   = rcnt_inc;
    n.win    = q.win + 32'h0000_0001;

    // Anti-chatter timer runs down to zero
    if (q.hold_t != 32'h0000_0000) begin
      n.hold_t = q.hold_t - 32'h0000_0001;
    end

    // Flash timebase for the indicator
    if (q.blink == BLINK_CYC - 1) begin
      n.blink = 32'h0000_0000;
      n.flash = ~q.flash;
    end else begin
      n.blink = q.blink + 32'h0000_0001;
    end

    // Window end: qualify references and step the controller
    if (win_end) begin
      n.win   = 32'h0000_0000;
      n.scnt  = 16'h0000;
      n.rcnt  = '0;
      n.ok    = ok_now;
      n.known = q.known | seen;
      n.exact = 1'b0;
      if (!act) begin
        n.state = rtc_pkg::RTC_FREE; // No quality record or free command
        n.inc   = `RTC_NOM_INC;      // Own clock, references ignored
      end else if (!have_want) begin
        n.state = rtc_pkg::RTC_HOLD; // Both out of spec, keep watching
      end else if (do_switch) begin
        // Failover or return to the preferred one
        n.sel    = want;
        n.hold_t = HOLDOFF_CYC;
        n.state  = rtc_pkg::RTC_TRACK;
      end else if (!ok_now[q.sel]) begin
        n.state = rtc_pkg::RTC_HOLD; // Frozen increment while switch is blocked
      end else if (q.state == rtc_pkg::RTC_LOCKED && aerr > 32'(BURST_TOL)) begin
        n.state = rtc_pkg::RTC_HOLD; // Error burst: hold rather than chase it
      end else if (q.state == rtc_pkg::RTC_FREE || q.state == rtc_pkg::RTC_HOLD) begin
        n.state = rtc_pkg::RTC_TRACK;
      end else if (aerr <= 32'(LOCK_TOL)) begin
        // Locked: keep nudging until counts agree exactly
        n.state = rtc_pkg::RTC_LOCKED;
        n.exact = (err == 32'sh0000_0000);
        if (err > 0) begin
          n.inc = q.inc - `RTC_LOCK_STEP;
        end else if (err < 0) begin
          n.inc = q.inc + `RTC_LOCK_STEP;
        end
      end else begin
        // Tracking: coarse steps toward the reference
        n.state = rtc_pkg::RTC_TRACK;
        n.inc   = (err > 0) ? q.inc - `RTC_TRACK_STEP : q.inc + `RTC_TRACK_STEP;
      end
    end

    // AHB-Lite data phase of a write
    n.wr_pend = 1'b0;
    if (q.wr_pend) begin
      if (q.waddr == `RTC_OFF_CTRL) begin
        n.en  = HWDATA[`RTC_CTRL_EN];
        n.cmd = rtc_pkg::rtc_cmd_e'(HWDATA[`RTC_CTRL_CMD_HI:`RTC_CTRL_CMD_LO]);
        n.ext = HWDATA[`RTC_CTRL_EXT];
        if (!q.en || !HWDATA[`RTC_CTRL_EN]) begin
          n.cmd = rtc_pkg::RTC_CMD_FREE; // Enable always starts in free-run
        end
        // Counts of the old set say nothing about the new one
        if (n.ext != q.ext) begin
          n.known = 2'b00; // New reference set has no quality record
          n.ok    = 2'b00;
          n.rcnt  = '0;
        end
        // A command takes effect at once
        if (n.cmd == rtc_pkg::RTC_CMD_FREE || n.known == 2'b00) begin
          n.state = rtc_pkg::RTC_FREE;
          n.inc   = `RTC_NOM_INC;
          n.exact = 1'b0; // Exact match only ever means locked
        end else if (n.cmd != q.cmd || !q.en) begin
          n.sel   = (n.cmd == rtc_pkg::RTC_CMD_SEC);
          n.state = rtc_pkg::RTC_TRACK;
          n.exact = 1'b0;
        end
      end
    end

    // AHB-Lite address phase
    if (addr_ph) begin
      n.wr_pend = HWRITE;
      n.waddr   = HADDR[7:0];
      n.hrdata  = 32'h0000_0000;
      if (!HWRITE) begin
        if (HADDR[7:0] == `RTC_OFF_CTRL) begin
          n.hrdata = {28'h000_0000, q.ext, q.cmd, q.en};
        end else if (HADDR[7:0] == `RTC_OFF_STATUS) begin
          n.hrdata = {22'h00_0000, q.exact, q.known, q.ok, q.sel, q.state};
        end else if (HADDR[7:0] == `RTC_OFF_FREQ) begin
          n.hrdata = q.inc;
        end
      end
    end

    // Indicator: flash while tracking, steady otherwise, dark when off
    if (!n.en) begin
      n.led = 1'b0;
    end else if (n.state == rtc_pkg::RTC_TRACK) begin
      n.led = n.flash;
    end else begin
      n.led = 1'b1;
    end
    n.hready = 1'b1;
  end

  // State register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q        <= '0;
      q.state  <= rtc_pkg::RTC_FREE;
      q.cmd    <= rtc_pkg::RTC_CMD_FREE;
      q.inc    <= `RTC_NOM_INC;
      q.hrdata <= `RTC_RST_HRDATA;
      q.hready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from flops, except HRESP which is tied low
  assign HRDATA     = q.hrdata;
  assign HREADYOUT  = q.hready;
  assign HRESP      = 1'b0;
  assign SYS_CLK    = q.sysclk;
  assign SYS_CLK_EN = q.en; // Disabled cards keep the clock off the backplane
  assign LED_GREEN  = q.led;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  enable_free_run_a: assert property ($rose(q.en) |-> q.state == rtc_pkg::RTC_FREE)
    else $error("enable did not start in free-run");
  free_nominal_a: assert property (q.state == rtc_pkg::RTC_FREE |-> q.inc == `RTC_NOM_INC)
    else $error("free-run not on own frequency");
  both_bad_hold_a: assert property (win_end && act && ok_now == 2'b00 && !q.wr_pend
    |=> q.state == rtc_pkg::RTC_HOLD)
    else $error("both references bad without holdover");
  auto_switch_a: assert property (win_end && act && !ok_now[q.sel] && ok_now[~q.sel]
    && q.hold_t == 32'h0000_0000 && !q.wr_pend |=> q.sel != $past(q.sel))
    else $error("no automatic switch to good reference");
  pref_return_a: assert property (win_end && act && ok_now[pref] && q.sel != pref
    && q.hold_t == 32'h0000_0000 && !q.wr_pend |=> q.sel == $past(pref) ##1 q.hold_t != 0)
    else $error("no return to preferred reference");
  holdoff_block_a: assert property (q.hold_t != 32'h0000_0000 && !q.wr_pend
    |=> $stable(q.sel))
    else $error("switch during anti-chatter time");
  led_flash_a: assert property (q.en && q.state == rtc_pkg::RTC_TRACK |-> q.led == q.flash)
    else $error("indicator not flashing while tracking");
  led_steady_a: assert property (q.en && q.state == rtc_pkg::RTC_LOCKED |-> q.led)
    else $error("indicator not steady when locked");
  no_record_free_a: assert property (win_end && q.known == 2'b00 && !q.wr_pend
    |=> q.state == rtc_pkg::RTC_FREE)
    else $error("free-run not entered without quality record");
  exact_locked_a: assert property (q.exact |-> q.state == rtc_pkg::RTC_LOCKED)
    else $error("exact match outside locked state");
  ahb_ready_a: assert property (HREADYOUT && !HRESP)
    else $error("slave must answer at once with OKAY");

  // Command writes take effect at the next edge
  free_cmd_a: assert property (q.wr_pend && q.waddr == `RTC_OFF_CTRL
    && HWDATA[`RTC_CTRL_CMD_HI:`RTC_CTRL_CMD_LO] == 2'h0 |=> q.state == rtc_pkg::RTC_FREE)
    else $error("free-run command not obeyed");
  disable_free_a: assert property (q.wr_pend && q.waddr == `RTC_OFF_CTRL
    && !HWDATA[`RTC_CTRL_EN] |=> !q.en && q.cmd == rtc_pkg::RTC_CMD_FREE)
    else $error("switching off did not clear the command");
  primary_cmd_a: assert property (q.wr_pend && q.waddr == `RTC_OFF_CTRL && q.en
    && HWDATA[2:0] == 3'h3 && HWDATA[`RTC_CTRL_EXT] == q.ext
    && q.cmd != rtc_pkg::RTC_CMD_PRI && q.known != 2'h0
    |=> !q.sel && q.state == rtc_pkg::RTC_TRACK)
    else $error("primary command did not select primary");
  secondary_cmd_a: assert property (q.wr_pend && q.waddr == `RTC_OFF_CTRL && q.en
    && HWDATA[2:0] == 3'h5 && HWDATA[`RTC_CTRL_EXT] == q.ext
    && q.cmd != rtc_pkg::RTC_CMD_SEC && q.known != 2'h0
    |=> q.sel && q.state == rtc_pkg::RTC_TRACK)
    else $error("secondary command did not select secondary");
  ext_clear_a: assert property (q.wr_pend && q.waddr == `RTC_OFF_CTRL
    && HWDATA[`RTC_CTRL_EXT] != q.ext |=> q.known == 2'h0 && q.state == rtc_pkg::RTC_FREE)
    else $error("new reference set kept an old quality record");

  // Window-end decisions of the controller
  track_start_a: assert property (win_end && act && have_want && !do_switch
    && ok_now[q.sel] && q.state == rtc_pkg::RTC_FREE && !q.wr_pend
    |=> q.state == rtc_pkg::RTC_TRACK)
    else $error("tracking did not start from free-run");
  lock_entry_a: assert property (win_end && act && have_want && !do_switch
    && ok_now[q.sel] && q.state == rtc_pkg::RTC_TRACK && aerr <= 32'(LOCK_TOL)
    && !q.wr_pend |=> q.state == rtc_pkg::RTC_LOCKED)
    else $error("close frequency did not lock");
  burst_hold_a: assert property (win_end && act && have_want && !do_switch
    && ok_now[q.sel] && q.state == rtc_pkg::RTC_LOCKED && aerr > 32'(BURST_TOL)
    && !q.wr_pend |=> q.state == rtc_pkg::RTC_HOLD)
    else $error("error burst not held over");
  hold_exit_a: assert property (win_end && act && have_want && !q.wr_pend
    && q.state == rtc_pkg::RTC_HOLD && (do_switch || ok_now[q.sel])
    |=> q.state == rtc_pkg::RTC_TRACK)
    else $error("holdover not left for a good reference");
  switch_good_a: assert property ($changed(q.sel) && !$past(q.wr_pend)
    |-> q.ok[q.sel])
    else $error("automatic switch to a bad reference");
  holdoff_load_a: assert property ($changed(q.sel) && !$past(q.wr_pend)
    |-> q.hold_t == HOLDOFF_CYC)
    else $error("automatic switch did not start the anti-chatter time");

  // Holdover keeps its frequency; a switched-off card stays dark
  hold_freeze_a: assert property (q.state == rtc_pkg::RTC_HOLD ##1
    q.state == rtc_pkg::RTC_HOLD |-> $stable(q.inc))
    else $error("frequency moved during holdover");
  led_dark_a: assert property (!q.en |-> !q.led)
    else $error("indicator lit while switched off");

  locked_c: cover property (q.state == rtc_pkg::RTC_TRACK ##1 q.state == rtc_pkg::RTC_LOCKED);
  hold_c: cover property (q.state == rtc_pkg::RTC_HOLD);
  switch_c: cover property (act && $changed(q.sel) && !$past(q.wr_pend));
  exact_c: cover property (q.exact);
  hold_exit_c: cover property (q.state == rtc_pkg::RTC_HOLD ##1 q.state == rtc_pkg::RTC_TRACK);

endmodule

// ===== rtc_ref_model.sv
// Reference clock sources feeding the selector's trunk and auxiliary inputs
`timescale 1ns/1ps
module rtc_ref_model #(
  parameter int unsigned HALF = 8 // Rising edge every 16 cycles: four per 64-cycle window
) (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [1:0] RUN_TRUNK,
  input  wire logic [1:0] RUN_AUX,
  output logic      [1:0] REF_TRUNK,
  output logic      [1:0] REF_AUX
);
  logic [7:0] cnt_q;
  logic       ph_q;
  // Shared phase; sources differ only in presence, not in rate
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q <= 8'h00;
      ph_q  <= 1'b0;
    end else if (cnt_q == 8'(HALF - 1)) begin
      cnt_q <= 8'h00;
      ph_q  <= ~ph_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // A lost source rests low, so it shows no edges at all
  assign REF_TRUNK = RUN_TRUNK & {2{ph_q}};
  assign REF_AUX   = RUN_AUX & {2{ph_q}};
endmodule

// ===== testbench.sv
// Self-checking bench for the reference clock selector
`timescale 1ns/1ps
`include "rtc_defs.svh"
module testbench;
  logic        CLK, RSTN, HSEL, HWRITE, HREADYOUT, HRESP, SYS_CLK, SYS_CLK_EN, LED_GREEN;
  logic [31:0] HADDR, HWDATA, HRDATA, d, f;
  logic [1:0]  HTRANS, REF_TRUNK, REF_AUX, run_trunk, run_aux;
  logic [2:0]  HSIZE;
  int          n_errors, n_checks, cyc, n;
  // One selector only, as a system keeps one controller active
  rtc_clock_selector #(.WIN_CYC(64), .HOLDOFF_CYC(300), .BLINK_CYC(8),
    .REF_EXP(16'h0004), .RATIO(16'h0003) // Tolerances keep their defaults
  ) u_dut (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .REF_TRUNK(REF_TRUNK), .REF_AUX(REF_AUX),
    .SYS_CLK(SYS_CLK), .SYS_CLK_EN(SYS_CLK_EN), .LED_GREEN(LED_GREEN));
  rtc_ref_model u_ref (.CLK(CLK), .RSTN(RSTN), .RUN_TRUNK(run_trunk), .RUN_AUX(run_aux),
    .REF_TRUNK(REF_TRUNK), .REF_AUX(REF_AUX));
  // Clock source
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Single AHB-Lite transfer; waits on the slave, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HADDR  <= {24'h00_0000, a};
    HWRITE <= wr;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HTRANS <= 2'b00;
    HWDATA <= wd;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    rd = HRDATA;
  endtask
  task automatic wr(input logic [31:0] v);
    ahb(1'b1, `RTC_OFF_CTRL, v, d);
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0000_0000, d);
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge CLK);
    rd(`RTC_OFF_STATUS);
  endtask
  // Hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    {n_errors, n_checks, cyc} = '0;
    {RSTN, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    HSIZE     = 3'h2;
    run_trunk = 2'b11;
    run_aux   = 2'b00;
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    // Reset values and an unmapped read
    rd(`RTC_OFF_STATUS);
    chk(d & 32'h0000_001F, 32'h0000_0001);
    rd(`RTC_OFF_CTRL);
    chk(d, 32'h0000_0000);
    rd(`RTC_OFF_FREQ);
    chk(d, `RTC_NOM_INC);
    rd(8'h0C);
    chk(d, 32'h0000_0000);
    chk({HRESP, SYS_CLK_EN, LED_GREEN}, 32'h0000_0000);
    // Enabling ignores a track command and free-runs at nominal rate
    wr(32'h0000_0003);
    rd(`RTC_OFF_CTRL);
    chk(d, 32'h0000_0001);
    n = 0;
    repeat (64) begin
      @(posedge CLK);
      if (SYS_CLK === 1'b1 && f[0] === 1'b0) n++;
      f[0] = SYS_CLK;
    end
    chk(32'(n >= 12 && n <= 14), 32'h0000_0001);
    waitc(200);
    chk(d & 32'h0000_000F, 32'h0000_0001);
    // Track primary with both sources good
    wr(32'h0000_0003);
    waitc(300);
    chk(d & 32'h0000_007F, 32'h0000_0064);
    repeat (16) begin
      @(posedge CLK);
      chk({31'h0, LED_GREEN}, 32'h0000_0001);
    end
    // Primary lost: fail over, then no quick return
    run_trunk <= 2'b10;
    waitc(200);
    chk(d & 32'h0000_0018, 32'h0000_0010);
    run_trunk <= 2'b11;
    waitc(100);
    chk(d & 32'h0000_0010, 32'h0000_0010);
    waitc(500);
    chk(d & 32'h0000_0010, 32'h0000_0000);
    // Both lost: holdover with frozen frequency
    run_trunk <= 2'b00;
    waitc(700);
    chk(d & 32'h0000_000F, 32'h0000_0008);
    rd(`RTC_OFF_FREQ);
    f = d;
    waitc(128);
    rd(`RTC_OFF_FREQ);
    chk(d, f);
    // Secondary recovers first, then primary
    run_trunk <= 2'b10;
    waitc(700);
    chk(d & 32'h0000_0018, 32'h0000_0010);
    run_trunk <= 2'b11;
    waitc(700);
    chk(d & 32'h0000_0010, 32'h0000_0000);
    // Secondary preference
    wr(32'h0000_0005);
    waitc(4);
    chk(d & 32'h0000_0010, 32'h0000_0010);
    run_trunk <= 2'b01;
    waitc(700);
    chk(d & 32'h0000_0018, 32'h0000_0000);
    run_trunk <= 2'b11;
    waitc(700);
    chk(d & 32'h0000_0010, 32'h0000_0010);
    // Free-run command
    wr(32'h0000_0001);
    waitc(200);
    chk(d & 32'h0000_000F, 32'h0000_0001);
    // Auxiliary set chosen while its sources are silent
    wr(32'h0000_000B);
    waitc(700);
    chk(d & 32'h0000_000F, 32'h0000_0001);
    run_aux <= 2'b11;
    waitc(700);
    chk(32'((d & 32'h0000_000F) != 32'h0000_0001), 32'h0000_0001);
    // Switching the controller off
    wr(32'h0000_0000);
    repeat (2) @(posedge CLK);
    chk({30'h0, SYS_CLK_EN, LED_GREEN}, 32'h0000_0000);
    end_of_test();
  end
endmodule
